// ===== src/mbt_cycle_ctl.sv
// Bank cycle timer: bank select priority, cycle counting and termination.
// Assumes a 20 MHz clock, one Avalon-MM master and address matching
// done outside, which presents one match bit per bank with each request.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "mbt_regs.svh"
module mbt_cycle_ctl (
   // Clock, reset and clock enable.
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    ce,
   // Avalon-MM register slave.
   input  wire logic [7:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   // Access request from a bus master.
   input  wire logic                    acc_request,
   input  wire logic [3:0]              acc_match,
   input  wire mbt_pkg::mbt_master_type acc_master,
   input  wire logic                    acc_write,
   input  wire logic                    acc_burst,
   input  wire logic                    acc_page_hit,
   input  wire logic                    acc_back_to_back,
   input  wire logic                    ext_ack,
   // Memory side and termination.
   output logic      [3:0]              bank_select,
   output logic      [1:0]              data_size_acknowledge,
   output logic                         transfer_acknowledge,
   output logic                         early_negate,
   output logic                         acc_busy,
   output logic                         acc_done
);
   import mbt_pkg::*;

   localparam int NB = `MBT_NBANKS;

   // Lowest set bit, so the lowest-numbered bank wins any overlap.
   function automatic logic [3:0] lowest(input logic [3:0] m);
      lowest = m & (~m + 4'h1);
   endfunction

   function automatic logic [1:0] onehot_idx(input logic [3:0] oh);
      onehot_idx = oh[1] ? 2'h1 : oh[2] ? 2'h2 : oh[3] ? 2'h3 : 2'h0;
   endfunction

   // Port-size code to the two acknowledge lines, high for asserted.
   function automatic logic [1:0] size_ack(input logic [1:0] code);
      size_ack = (code == 2'h0) ? 2'b11 : (code == 2'h1) ? 2'b10
               : (code == 2'h2) ? 2'b01 : 2'b00;
   endfunction

   logic            wait_r;
   logic [31:0]     rdata_r;
   mbt_global_type  global_r;
   mbt_bank_type    bank_r [NB];
   mbt_state_type   state_r;
   mbt_bank_type    cfg_act_r;
   mbt_master_type  master_r;
   logic [3:0]      sel_r;
   logic [4:0]      cnt_r;
   logic [4:0]      first_len_r;
   logic [2:0]      beat_len_r;
   logic [1:0]      beats_left_r;
   logic [1:0]      port_r;
   logic            write_r;
   logic            hit_r;
   logic            first_r;
   logic            fin_r;
   logic            neg_r;
   logic [1:0]      dsack_r;
   logic            tack_r;
   logic            busy_r;
   logic            done_r;
   logic [7:0]      clocks_r;
   logic [7:0]      last_clocks_r;
   logic [4:0]      seg_clk_r;

   mbt_len_if lif ();
   mbt_len_calc u_len (
      .lif (lif.calc)
   );

   // Bus decoding.
   wire        bus_req   = avs_read | avs_write;
   wire        wr_go     = avs_write & ~wait_r;
   wire        sel_glob  = avs_address == `MBT_OFF_GLOBAL;
   wire        sel_stat  = avs_address == `MBT_OFF_STATUS;
   wire        sel_bank  = avs_address[7:4] == `MBT_BANK_PAGE
                           && avs_address[1:0] == 2'h0;
   wire [1:0]  bus_idx   = avs_address[3:2];
   wire [31:0] stat_word = {16'h0000, last_clocks_r, 2'h0, state_r,
                            onehot_idx(sel_r), port_r};
   wire [31:0] rd_mux    = sel_glob ? {23'h0, global_r}
                         : sel_stat ? stat_word
                         : sel_bank ? {18'h0, bank_r[bus_idx]}
                         : 32'h0000_0000;

   // Access decoding; disabled banks never match.
   logic [3:0] en_vec;
   for (genvar b = 0; b < NB; b++) begin : g_en
      assign en_vec[b] = bank_r[b].bank_enable;
   end
   wire [3:0] pick     = lowest(acc_match & en_vec);
   wire [1:0] pick_idx = onehot_idx(pick);
   wire       start    = state_r == mbt_st_idle && acc_request
                         && pick != 4'h0;
   wire       req_brst = acc_burst & (acc_master == mbt_master_burst);
   wire [1:0] req_port = bank_r[pick_idx].dram_select
                         ? global_r.dram_port_size
                         : bank_r[pick_idx].sram_port_size;

   assign lif.cfg          = bank_r[pick_idx];
   assign lif.gcfg         = global_r;
   assign lif.master       = acc_master;
   assign lif.write        = acc_write;
   assign lif.page_hit     = acc_page_hit;
   assign lif.back_to_back = acc_back_to_back;

   // Segment sequencing.
   wire in_run   = state_r == mbt_st_run;
   wire seg_end  = in_run && cnt_r == 5'h00;
   wire more     = seg_end && beats_left_r != 2'h0;
   wire fin_nxt  = in_run && (cnt_r == 5'h01
                  || (more && beat_len_r == 3'h1));
   wire last_nxt = fin_nxt && (more ? beats_left_r == 2'h1
                                    : beats_left_r == 2'h0);
   wire neg_opt  = master_r == mbt_master_burst
                   ? cfg_act_r.early_select_negate_burst_bus
                   : cfg_act_r.early_select_negate_classic;
   // External acknowledge is not honoured before the minimum for classic.
   wire ext_ok   = master_r != mbt_master_classic
                   || clocks_r >= {3'h0, `MBT_CLK_EXT_MIN};
   wire cyc_end  = (seg_end && !more)
                   || (state_r == mbt_st_extw && ext_ack && ext_ok);

   // Avalon answers one cycle after the request; read data is latched then.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         wait_r <= !(bus_req && wait_r);
         if (avs_read && wait_r) begin
            rdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         global_r <= `MBT_GLOBAL_RESET;
      end else if (ce && wr_go && sel_glob) begin
         global_r <= avs_writedata[`MBT_GLOBAL_W-1:0];
      end
   end

   for (genvar b = 0; b < NB; b++) begin : g_bank
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            bank_r[b] <= `MBT_BANK_RESET;
         end else if (ce && wr_go && sel_bank && bus_idx == 2'(b)) begin
            bank_r[b] <= avs_writedata[`MBT_BANK_W-1:0];
         end
      end
   end

   // Settings are latched at the start, so a register write during a
   // cycle cannot move its select edge or its length.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_act_r   <= `MBT_BANK_RESET;
         master_r    <= mbt_master_internal;
         write_r     <= 1'b0;
         hit_r       <= 1'b0;
         port_r      <= 2'h0;
         first_len_r <= 5'h00;
         beat_len_r  <= 3'h1;
      end else if (ce && start) begin
         cfg_act_r   <= bank_r[pick_idx];
         master_r    <= acc_master;
         write_r     <= acc_write;
         hit_r       <= acc_page_hit;
         port_r      <= req_port;
         first_len_r <= lif.first_len;
         beat_len_r  <= lif.beat_len;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r      <= mbt_st_idle;
         sel_r        <= 4'h0;
         cnt_r        <= 5'h00;
         beats_left_r <= 2'h0;
         first_r      <= 1'b0;
         seg_clk_r    <= 5'h00;
      end else if (ce) begin
         unique case (state_r)
            mbt_st_idle: begin
               if (start) begin
                  sel_r     <= pick;
                  first_r   <= 1'b1;
                  seg_clk_r <= 5'h01;
                  if (lif.ext_term) begin
                     state_r <= mbt_st_extw;
                  end else begin
                     state_r      <= mbt_st_run;
                     cnt_r        <= lif.first_len - 5'h01;
                     beats_left_r <= req_brst ? `MBT_LATER_BEATS : 2'h0;
                  end
               end
            end
            mbt_st_run: begin
               if (more) begin
                  cnt_r        <= {2'h0, beat_len_r} - 5'h01;
                  beats_left_r <= beats_left_r - 2'h1;
                  first_r      <= 1'b0;
                  seg_clk_r    <= 5'h01;
               end else if (seg_end) begin
                  state_r <= mbt_st_idle;
                  sel_r   <= 4'h0;
               end else begin
                  cnt_r     <= cnt_r - 5'h01;
                  seg_clk_r <= seg_clk_r + 5'h01;
               end
            end
            mbt_st_extw: begin
               if (ext_ack && ext_ok) begin
                  state_r <= mbt_st_idle;
                  sel_r   <= 4'h0;
               end
            end
         endcase
      end
   end

   // Termination strobes, registered into the final clock; acc_done follows one clock later.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fin_r   <= 1'b0;
         dsack_r <= 2'h0;
         tack_r  <= 1'b0;
         neg_r   <= 1'b0;
         done_r  <= 1'b0;
         busy_r  <= 1'b0;
      end else if (ce) begin
         fin_r   <= fin_nxt;
         dsack_r <= (fin_nxt && master_r != mbt_master_burst)
                    ? size_ack(port_r) : 2'h0;
         tack_r  <= fin_nxt && master_r == mbt_master_burst;
         neg_r   <= last_nxt && write_r && neg_opt;
         done_r  <= cyc_end;
         busy_r  <= start || (busy_r && !cyc_end);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clocks_r      <= 8'h00;
         last_clocks_r <= 8'h00;
      end else if (ce) begin
         if (start) begin
            clocks_r <= 8'h01;
         end else if (state_r != mbt_st_idle && clocks_r != 8'hFF) begin
            clocks_r <= clocks_r + 8'h01;
         end
         if (cyc_end) begin
            last_clocks_r <= clocks_r;
         end
      end
   end

   assign avs_readdata          = rdata_r;
   assign avs_waitrequest       = wait_r;
   assign bank_select           = sel_r;
   assign data_size_acknowledge = dsack_r;
   assign transfer_acknowledge  = tack_r;
   assign early_negate          = neg_r;
   assign acc_busy              = busy_r;
   assign acc_done              = done_r;

   default clocking cb @(posedge clock iff ce);
   endclocking
   default disable iff (rst);

   property p_prio;
      start |=> bank_select == lowest($past(acc_match & en_vec));
   endproperty
   a_prio: assert property (p_prio)
      else $error("bank select is not the lowest matching bank");

   property p_first_len;
      fin_r && first_r && master_r != mbt_master_burst
         |-> clocks_r == {3'h0, first_len_r};
   endproperty
   a_first_len: assert property (p_first_len)
      else $error("first access length differs from computed length");

   property p_beat;
      fin_r && !first_r |-> seg_clk_r ==
         {3'h0, cfg_act_r.burst_beat_length} + 5'h01
         + {4'h0, cfg_act_r.dram_select};
   endproperty
   a_beat: assert property (p_beat)
      else $error("later burst beat has the wrong length");

   property p_ext_wait;
      state_r == mbt_st_extw && !ext_ack
         |=> state_r == mbt_st_extw && $stable(bank_select)
             && data_size_acknowledge == 2'h0 && !transfer_acknowledge;
   endproperty
   a_ext_wait: assert property (p_ext_wait)
      else $error("external acknowledge cycle ended without acknowledge");

   property p_int_sram;
      fin_r && master_r == mbt_master_internal && !cfg_act_r.dram_select
         && !cfg_act_r.timing_relax && !write_r
         |-> clocks_r == {4'h0, cfg_act_r.cycle_length_field} + 8'h02;
   endproperty
   a_int_sram: assert property (p_int_sram)
      else $error("internal SRAM read length is not field plus two");

   property p_dram_two;
      fin_r && first_r && cfg_act_r.dram_select && clocks_r == 8'h02
         |-> master_r == mbt_master_internal && hit_r
             && cfg_act_r.page_mode_enable;
   endproperty
   a_dram_two: assert property (p_dram_two)
      else $error("two-clock DRAM access without internal page hit");

   property p_ext_min;
      acc_done && master_r == mbt_master_classic
         |-> last_clocks_r >= 8'h03;
   endproperty
   a_ext_min: assert property (p_ext_min)
      else $error("classic external cycle shorter than three clocks");

   property p_negate;
      early_negate |-> (data_size_acknowledge != 2'h0
         || transfer_acknowledge) ##1 (bank_select == 4'h0 && acc_done);
   endproperty
   a_negate: assert property (p_negate)
      else $error("early negate outside the final clock");

   property p_release;
      $fell(acc_busy) |-> acc_done && $past(fin_r || ext_ack);
   endproperty
   a_release: assert property (p_release)
      else $error("bank released without termination");
endmodule

// ===== src/mbt_len_calc.sv
// Works out the clock count of a first access and of later burst beats.
// Assumes the controller presents a stable access description through lif.
`timescale 1ns/1ns
`include "mbt_regs.svh"
module mbt_len_calc (
   // Access description in, lengths out.
   mbt_len_if.calc lif
);
   import mbt_pkg::*;

   wire       is_int   = lif.master == mbt_master_internal;
   wire       is_burst = lif.master == mbt_master_burst;
   wire       is_cls   = ~is_int & ~is_burst;
   wire       dram     = lif.cfg.dram_select;
   // Burst-bus masters never get page mode.
   wire       page     = dram & lif.cfg.page_mode_enable & ~is_burst;
   wire [4:0] dram_pg  = lif.page_hit ? `MBT_CLK_PAGE_HIT
                                      : `MBT_CLK_PAGE_MISS;
   wire [4:0] dram_np  = lif.back_to_back ? `MBT_CLK_B2B
                                          : `MBT_CLK_DRAM_BASE;
   wire [4:0] base     = dram ? (page ? dram_pg : dram_np)
                              : `MBT_CLK_SRAM_BASE;
   // Classic masters pay one clock, except on a back-to-back DRAM access without page mode.
   wire       cls_add  = is_cls & ~(dram & ~page & lif.back_to_back);
   wire       relax    = lif.cfg.timing_relax & ~is_burst
                         & ~(is_cls & ~dram & ~lif.gcfg.sync);
   wire       tss_add  = is_burst & lif.gcfg.burst_bus_start_delay;
   wire       xwt_add  = is_cls & lif.gcfg.external_master_wait;
   wire       dw_opt   = is_burst ? lif.gcfg.delay_write_burst_bus
                                  : lif.gcfg.delay_write_classic;
   wire       wb_opt   = is_burst ? lif.gcfg.write_buffer_burst_bus
                                  : lif.gcfg.write_buffer_classic;
   wire       dw_add   = lif.write & dw_opt & ~wb_opt;
   wire [4:0] raw_len  = {1'b0, lif.cfg.cycle_length_field} + base
                         + {4'h0, cls_add} + {4'h0, relax} + {4'h0, tss_add}
                         + {4'h0, xwt_add} + {4'h0, dw_add};

   assign lif.first_len = (is_cls && raw_len < `MBT_CLK_EXT_MIN)
                          ? `MBT_CLK_EXT_MIN : raw_len;
   assign lif.beat_len  = {1'b0, lif.cfg.burst_beat_length} + 3'h1
                          + {2'h0, dram};
   assign lif.ext_term  = dram ? lif.gcfg.dram_port_size == `MBT_PORT_EXT
                        : lif.cfg.sram_port_size == `MBT_PORT_EXT;
endmodule

// ===== src/mbt_len_if.sv
// Carries one access description to the length calculator and its answer.
// Purely combinational; the controller owns all state.
`timescale 1ns/1ns
interface mbt_len_if;
   import mbt_pkg::*;
   mbt_bank_type   cfg;
   mbt_global_type gcfg;
   mbt_master_type master;
   logic           write;
   logic           page_hit;
   logic           back_to_back;
   logic [4:0]     first_len;
   logic [2:0]     beat_len;
   logic           ext_term;
   modport ctl  (output cfg, gcfg, master, write, page_hit, back_to_back,
                 input first_len, beat_len, ext_term);
   modport calc (input cfg, gcfg, master, write, page_hit, back_to_back,
                 output first_len, beat_len, ext_term);
endinterface

// ===== src/mbt_pkg.sv
// Types shared by the bank cycle timer and its length calculator.
// Field order inside the structs is the bit layout of the registers.
package mbt_pkg;

   typedef enum logic [1:0] {
      mbt_master_internal = 2'b00,
      mbt_master_classic  = 2'b01,
      mbt_master_burst    = 2'b10
   } mbt_master_type;

   typedef enum logic [1:0] {
      mbt_st_idle = 2'b00,
      mbt_st_run  = 2'b01,
      mbt_st_extw = 2'b10
   } mbt_state_type;

   typedef struct packed {
      logic       bank_enable;
      logic       early_select_negate_burst_bus;
      logic       early_select_negate_classic;
      logic       timing_relax;
      logic [1:0] burst_beat_length;
      logic       page_mode_enable;
      logic       dram_select;
      logic [1:0] sram_port_size;
      logic [3:0] cycle_length_field;
   } mbt_bank_type;

   typedef struct packed {
      logic [1:0] dram_port_size;
      logic       delay_write_burst_bus;
      logic       delay_write_classic;
      logic       write_buffer_burst_bus;
      logic       write_buffer_classic;
      logic       sync;
      logic       external_master_wait;
      logic       burst_bus_start_delay;
   } mbt_global_type;

endpackage

// ===== src/mbt_regs.svh
// Register offsets, reset values and clock counts of the bank cycle timer.
// Included by every design file that needs a number; holds no logic.
`ifndef MBT_REGS_SVH
`define MBT_REGS_SVH

`define MBT_NBANKS         4
`define MBT_OFF_GLOBAL     8'h00
`define MBT_OFF_STATUS     8'h04
`define MBT_BANK_PAGE      4'h1
`define MBT_GLOBAL_W       9
`define MBT_BANK_W         14
`define MBT_GLOBAL_RESET   9'h000
`define MBT_BANK_RESET     14'h000F
`define MBT_PORT_EXT       2'h3
`define MBT_CLK_SRAM_BASE  5'h02
`define MBT_CLK_DRAM_BASE  5'h03
`define MBT_CLK_PAGE_HIT   5'h02
`define MBT_CLK_PAGE_MISS  5'h04
`define MBT_CLK_B2B        5'h04
`define MBT_CLK_EXT_MIN    5'h03
`define MBT_LATER_BEATS    2'h3
`define MBT_STAT_CLK_POS   8

`endif

// ===== verif/mbt_cycle_ctl_tb_top.sv
// Self-checking bench: registers over Avalon-MM, then timed accesses.
// Assumes the controller answers each register request in bounded time.
`timescale 1ns/1ns
module mbt_cycle_ctl_tb_top;
   import mbt_pkg::*;
   logic        clock = 0, rst = 1, avs_read = 0, avs_write = 0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic        avs_waitrequest, acc_request = 0, acc_write = 0, acc_burst = 0;
   logic [3:0]  acc_match = 4'h0, bank_select, sel;
   logic        acc_page_hit = 0, acc_back_to_back = 0, ext_ack, neg;
   logic [1:0]  data_size_acknowledge, ds;
   logic        transfer_acknowledge, early_negate, acc_busy, acc_done;
   logic [4:0]  ack_delay = 5'h05;
   mbt_master_type acc_master = mbt_master_internal;
   int          fails = 0, n_compared = 0, cyc = 0, tot, ack[$];

   always #25 clock = ~clock;

   mbt_cycle_ctl dut (.clock(clock), .rst(rst), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .acc_request(acc_request),
      .acc_match(acc_match), .acc_master(acc_master), .acc_write(acc_write),
      .acc_burst(acc_burst), .acc_page_hit(acc_page_hit),
      .acc_back_to_back(acc_back_to_back), .ext_ack(ext_ack),
      .bank_select(bank_select),
      .data_size_acknowledge(data_size_acknowledge),
      .transfer_acknowledge(transfer_acknowledge),
      .early_negate(early_negate), .acc_busy(acc_busy), .acc_done(acc_done));

   mbt_ext_mem_model mem (.clock(clock), .rst(rst), .bank_select(bank_select),
      .ack_delay(ack_delay), .ext_ack(ext_ack));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Request stays up until the edge that sees waitrequest low.
   // An extra edge at the end keeps two calls from driving one time step.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask

   // Records select, acknowledge positions and total length of one access.
   task automatic run(input mbt_master_type m, input logic [3:0] mt,
                      input logic b, input logic h, input logic w);
      tot = 0;
      sel = 4'h0;
      neg = 1'b0;
      ds = 2'h0;
      ack.delete();
      acc_master <= m;
      acc_match <= mt;
      acc_burst <= b;
      acc_page_hit <= h;
      acc_write <= w;
      acc_request <= 1'b1;
      @(posedge clock);
      acc_request <= 1'b0;
      for (int n = 0; n < 60; n++) begin
         @(negedge clock);
         if (acc_done === 1'b1) break;
         chk(acc_busy, bank_select != 4'h0);
         if (bank_select != 4'h0) tot++;
         sel |= bank_select;
         ds |= data_size_acknowledge;
         if (early_negate === 1'b1) neg = 1'b1;
         if (data_size_acknowledge != 2'h0 || transfer_acknowledge === 1'b1)
            ack.push_back(tot);
      end
      @(posedge clock);
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         $display("[FAIL] %0t timeout", $time);
         conclude();
      end
   end

   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      bus(0, 8'h10, 0); chk(q, 32'h0000000F);
      bus(0, 8'h00, 0); chk(q, 32'h0);
      bus(1, 8'h08, 32'hFFFF); bus(0, 8'h08, 0); chk(q, 32'h0);
      $display("test reset_regs done");
      for (int f = 0; f < 16; f += 5) begin
         bus(1, 8'h10, 32'h2000 | f);
         run(mbt_master_internal, 4'h1, 0, 0, 0);
         chk(tot, f + 2);
         chk(ack[0], f + 2);
         chk(sel, 4'h1);
      end
      $display("test internal_sram done");
      bus(1, 8'h14, 32'h2040); run(mbt_master_internal, 4'h2, 0, 0, 0);
      chk(tot, 3);
      acc_back_to_back <= 1'b1; run(mbt_master_internal, 4'h2, 0, 0, 0);
      chk(tot, 4);
      run(mbt_master_classic, 4'h2, 0, 0, 0); chk(tot, 4);
      acc_back_to_back <= 1'b0;
      bus(1, 8'h14, 32'h2041); run(mbt_master_internal, 4'h2, 0, 0, 0);
      chk(tot, 4);
      bus(1, 8'h14, 32'h20C0); run(mbt_master_internal, 4'h2, 0, 1, 0);
      chk(tot, 2);
      run(mbt_master_internal, 4'h2, 0, 0, 0); chk(tot, 4);
      run(mbt_master_classic, 4'h2, 0, 1, 0); chk(tot, 3);
      $display("test dram done");
      bus(1, 8'h10, 32'h2000); run(mbt_master_classic, 4'h1, 0, 0, 0);
      chk(tot, 3);
      bus(1, 8'h1C, 32'h2000); run(mbt_master_internal, 4'h9, 0, 0, 0);
      chk(sel, 4'h1);
      $display("test classic_priority done");
      bus(1, 8'h10, 32'h2100); run(mbt_master_burst, 4'h1, 1, 0, 0);
      for (int i = 0; i < 4; i++) chk(ack[i], 2 + 2 * i);
      chk(tot, 8);
      chk(ds, 2'h0);
      bus(1, 8'h10, 32'h2800); run(mbt_master_classic, 4'h1, 0, 0, 1);
      chk(tot, 3);
      chk(neg, 1'b1);
      chk(ds, 2'h3);
      $display("test burst_negate done");
      // Field kept nonzero while the bank waits for its own acknowledge.
      bus(1, 8'h18, 32'h203F);
      run(mbt_master_internal, 4'h4, 0, 0, 0);
      chk(tot, 5);
      chk(ack.size(), 0);
      bus(0, 8'h04, 0); chk(q, 32'h00000503);
      $display("test ext_ack done");
      bus(1, 8'h10, 32'h2400); run(mbt_master_internal, 4'h1, 0, 0, 0);
      chk(tot, 3);
      bus(1, 8'h00, 32'h2); run(mbt_master_classic, 4'h1, 0, 0, 0);
      chk(tot, 4);
      bus(1, 8'h00, 32'h1); bus(1, 8'h10, 32'h2000);
      run(mbt_master_burst, 4'h1, 1, 0, 0); chk(tot, 6);
      chk(ack[0], 3);
      bus(1, 8'h00, 32'h0);
      $display("test settings done");
      conclude();
   end
endmodule

// ===== verif/mbt_ext_mem_model.sv
// External memory that ends its cycles with its own acknowledge.
// Assumes one bank select bus from the controller and one system clock.
`timescale 1ns/1ns
module mbt_ext_mem_model (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst,
   // Controller side.
   input  wire logic [3:0] bank_select,
   input  wire logic [4:0] ack_delay,
   output logic            ext_ack
);
   logic [4:0] cnt_r;

   // The delay counts clocks of the select, so a slow or prompt part is
   // just a different delay; the line is low whenever no bank is selected.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= (bank_select != 4'h0) ? cnt_r + 5'h01 : 5'h00;
      end
   end

   assign ext_ack = (bank_select != 4'h0)
                    && (cnt_r == ack_delay - 5'h01);
endmodule
